// *** srt_pkg.sv ***
package srt_pkg;

   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
   localparam logic [7:0] ADDR_RELOAD_LOW_BYTE = 8'hCA;
   localparam logic [7:0] ADDR_RELOAD_HIGH_BYTE = 8'hCB;
   localparam logic [7:0] ADDR_COUNT_LOW_BYTE = 8'hCC;
   localparam logic [7:0] ADDR_COUNT_HIGH_BYTE = 8'hCD;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTRL_HIGH_OVERFLOW = 7;
   localparam int CTRL_LOW_OVERFLOW = 6;
   localparam int CTRL_LOW_IRQ_ENABLE = 5;
   localparam int CTRL_UNUSED_HI = 4;
   localparam int CTRL_SPLIT_MODE = 3;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_UNUSED_LO = 1;
   localparam int CTRL_EXT_CLOCK = 0;

   // ****************************************************************
   // Reset values and counter limits
   // ****************************************************************
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ****************************************************************
   // Clock source timing
   // ****************************************************************
   localparam int SYS_CLOCK_MHZ = 100;
   localparam int SYS_DIVIDE = 12;
   localparam int EXT_DIVIDE = 8;

endpackage

// *** srt_clk_src.sv ***
`timescale 1ns/1ns
module srt_clk_src #(
   parameter int SYS_DIV = srt_pkg::SYS_DIVIDE,
   parameter int EXT_DIV = srt_pkg::EXT_DIVIDE
)(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ext_osc,
   output logic tick_sys,
   output logic tick_ext
);

   localparam int SW = $clog2(SYS_DIV);
   localparam int EW = $clog2(EXT_DIV);
   localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
   localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);
   localparam logic [SW-1:0] SYS_ZERO = '0;
   localparam logic [EW-1:0] EXT_ZERO = '0;

   generate
      if (SYS_DIV < 2 || EXT_DIV < 2)
      begin : g_bad_div
         $error("srt_clk_src: dividers must be at least 2");
      end
   endgenerate

   // ****************************************************************
   // System clock divider
   // ****************************************************************
   logic [SW-1:0] sys_cnt_q;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sys_cnt_q <= SYS_ZERO;
         tick_sys <= 1'b0;
      end
      else
      begin
         tick_sys <= (sys_cnt_q == SYS_LAST);
         if (sys_cnt_q == SYS_LAST)
            sys_cnt_q <= SYS_ZERO;
         else
            sys_cnt_q <= sys_cnt_q + SW'(1);
      end
   end

   // ****************************************************************
   // External oscillator synchroniser and divider
   // ****************************************************************
   // Oscillator must not run faster than half ref_clk or edges are lost
   logic sync1_q, sync2_q, sync3_q;
   logic [EW-1:0] ext_cnt_q;
   logic ext_rise;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end
      else
      begin
         sync1_q <= ext_osc;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign ext_rise = sync2_q & ~sync3_q;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ext_cnt_q <= EXT_ZERO;
         tick_ext <= 1'b0;
      end
      else
      begin
         tick_ext <= ext_rise && (ext_cnt_q == EXT_LAST);
         if (ext_rise)
         begin
            if (ext_cnt_q == EXT_LAST)
               ext_cnt_q <= EXT_ZERO;
            else
               ext_cnt_q <= ext_cnt_q + EW'(1);
         end
      end
   end

   a_sys_tick_gap: assert property (@(posedge ref_clk)
      disable iff (reset) tick_sys |=> !tick_sys [*8])
      else $error("system divider tick too early");

   a_ext_tick_gap: assert property (@(posedge ref_clk)
      disable iff (reset) tick_ext |=> !tick_ext [*3])
      else $error("external divider tick too early");

endmodule

// *** srt_timer.sv ***
`timescale 1ns/1ns
// Behaviour
// - Split bit picks 16-bit or dual 8-bit
// - 16-bit wrap reloads both bytes, sets high flag
// - Timer irq enable requests on high overflow
// - Split bytes each reload from own byte
// - Run gates all, or high byte in split
// - Per-byte select: system clock or alternate source
// - External divided clock synchronised to system clock
// - External select picks divide-12 or external/8
// - High byte wrap sets high overflow flag
// - Low byte wrap sets low overflow flag
// - Flags cleared only by software writes
// - Split: low enable requests on either overflow
// - 16-bit: low enable requests on low wrap
// - Control bits 4 and 1 read zero
// - Low count register readable and writable
// - 16-bit uses low byte clock select only
// - High count register readable and writable
module srt_timer #(
   parameter int SYS_DIV = srt_pkg::SYS_DIVIDE,
   parameter int EXT_DIV = srt_pkg::EXT_DIVIDE
)(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic low_byte_clock_select,
   input wire logic high_byte_clock_select,
   input wire logic timer_irq_enable,
   input wire logic ext_osc,
   output logic irq_request
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic high_overflow_flag_q;
   logic low_overflow_flag_q;
   logic low_byte_irq_enable_q;
   logic split_mode_select_q;
   logic run_control_q;
   logic external_clock_select_q;
   logic [7:0] reload_low_byte_q;
   logic [7:0] reload_high_byte_q;
   logic [7:0] count_low_byte_q;
   logic [7:0] count_high_byte_q;
   logic [7:0] count_low_byte_d;
   logic [7:0] count_high_byte_d;
   logic [7:0] ctrl_view;

   // ****************************************************************
   // Write decode
   // ****************************************************************
   logic wr_ctrl, wr_rl_lo, wr_rl_hi, wr_cnt_lo, wr_cnt_hi;

   assign wr_ctrl = sfr_wr && (sfr_addr == srt_pkg::ADDR_TIMER_CONTROL);
   assign wr_rl_lo = sfr_wr && (sfr_addr == srt_pkg::ADDR_RELOAD_LOW_BYTE);
   assign wr_rl_hi = sfr_wr && (sfr_addr == srt_pkg::ADDR_RELOAD_HIGH_BYTE);
   assign wr_cnt_lo = sfr_wr && (sfr_addr == srt_pkg::ADDR_COUNT_LOW_BYTE);
   assign wr_cnt_hi = sfr_wr && (sfr_addr == srt_pkg::ADDR_COUNT_HIGH_BYTE);

   // ****************************************************************
   // Clock sources
   // ****************************************************************
   logic tick_sys, tick_ext, tick_alt, tick_lo, tick_hi;

   srt_clk_src #(
      .SYS_DIV(SYS_DIV),
      .EXT_DIV(EXT_DIV)
   ) u_clk_src (
      .ref_clk(ref_clk),
      .reset(reset),
      .ext_osc(ext_osc),
      .tick_sys(tick_sys),
      .tick_ext(tick_ext)
   );

   // Alternate source shared by both bytes
   assign tick_alt = external_clock_select_q ? tick_ext
                                             : tick_sys;
   assign tick_lo = low_byte_clock_select ? 1'b1 : tick_alt;
   // High select only matters in split mode
   assign tick_hi = high_byte_clock_select ? 1'b1 : tick_alt;

   // ****************************************************************
   // Count enables, wraps and reloads
   // ****************************************************************
   logic en_lo, en_hi, wrap_lo, wrap_hi, reload_lo, reload_hi;

   // Low byte ignores run control in split mode
   assign en_lo = split_mode_select_q ? tick_lo
                                      : (run_control_q & tick_lo);
   // In 16-bit mode the high byte advances on the low carry
   assign en_hi = split_mode_select_q ? (run_control_q & tick_hi)
      : (en_lo && count_low_byte_q == srt_pkg::BYTE_MAX);
   assign wrap_lo = en_lo && (count_low_byte_q == srt_pkg::BYTE_MAX);
   assign wrap_hi = en_hi && (count_high_byte_q == srt_pkg::BYTE_MAX);
   // Low byte only reloads on its own wrap in split mode
   assign reload_lo = split_mode_select_q ? wrap_lo : wrap_hi;
   assign reload_hi = wrap_hi;

   // ****************************************************************
   // Counters
   // ****************************************************************
   // A software write beats a count in the same cycle
   always_comb
   begin
      count_low_byte_d = count_low_byte_q;
      if (wr_cnt_lo)
         count_low_byte_d = sfr_wdata;
      else if (reload_lo)
         count_low_byte_d = reload_low_byte_q;
      else if (en_lo)
         count_low_byte_d = count_low_byte_q + srt_pkg::BYTE_ONE;
   end

   always_comb
   begin
      count_high_byte_d = count_high_byte_q;
      if (wr_cnt_hi)
         count_high_byte_d = sfr_wdata;
      else if (reload_hi)
         count_high_byte_d = reload_high_byte_q;
      else if (en_hi)
         count_high_byte_d = count_high_byte_q + srt_pkg::BYTE_ONE;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         count_low_byte_q <= srt_pkg::RESET_BYTE;
      else
         count_low_byte_q <= count_low_byte_d;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         count_high_byte_q <= srt_pkg::RESET_BYTE;
      else
         count_high_byte_q <= count_high_byte_d;
   end

   // ****************************************************************
   // Reload registers
   // ****************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         reload_low_byte_q <= srt_pkg::RESET_BYTE;
         reload_high_byte_q <= srt_pkg::RESET_BYTE;
      end
      else
      begin
         if (wr_rl_lo)
            reload_low_byte_q <= sfr_wdata;
         if (wr_rl_hi)
            reload_high_byte_q <= sfr_wdata;
      end
   end

   // ****************************************************************
   // Control register
   // ****************************************************************
   // Bits 4 and 1 have no storage, so writes to them vanish
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         low_byte_irq_enable_q <= 1'b0;
         split_mode_select_q <= 1'b0;
         run_control_q <= 1'b0;
         external_clock_select_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         low_byte_irq_enable_q <= sfr_wdata[srt_pkg::CTRL_LOW_IRQ_ENABLE];
         split_mode_select_q <= sfr_wdata[srt_pkg::CTRL_SPLIT_MODE];
         run_control_q <= sfr_wdata[srt_pkg::CTRL_RUN];
         external_clock_select_q <= sfr_wdata[srt_pkg::CTRL_EXT_CLOCK];
      end
   end

   // Hardware only sets; an overflow in the clearing cycle still lands
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         high_overflow_flag_q <= 1'b0;
      else if (wrap_hi)
         high_overflow_flag_q <= 1'b1;
      else if (wr_ctrl)
         high_overflow_flag_q <=
            sfr_wdata[srt_pkg::CTRL_HIGH_OVERFLOW];
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         low_overflow_flag_q <= 1'b0;
      else if (wrap_lo)
         low_overflow_flag_q <= 1'b1;
      else if (wr_ctrl)
         low_overflow_flag_q <=
            sfr_wdata[srt_pkg::CTRL_LOW_OVERFLOW];
   end

   always_comb
   begin
      ctrl_view = srt_pkg::RESET_BYTE;
      ctrl_view[srt_pkg::CTRL_HIGH_OVERFLOW] = high_overflow_flag_q;
      ctrl_view[srt_pkg::CTRL_LOW_OVERFLOW] = low_overflow_flag_q;
      ctrl_view[srt_pkg::CTRL_LOW_IRQ_ENABLE] = low_byte_irq_enable_q;
      ctrl_view[srt_pkg::CTRL_SPLIT_MODE] = split_mode_select_q;
      ctrl_view[srt_pkg::CTRL_RUN] = run_control_q;
      ctrl_view[srt_pkg::CTRL_EXT_CLOCK] = external_clock_select_q;
      ctrl_view[srt_pkg::CTRL_UNUSED_HI] = 1'b0;
      ctrl_view[srt_pkg::CTRL_UNUSED_LO] = 1'b0;
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   // Read data is registered, one cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         sfr_rdata <= srt_pkg::RESET_BYTE;
      else if (sfr_rd)
      begin
         case (sfr_addr)
            srt_pkg::ADDR_TIMER_CONTROL: sfr_rdata <= ctrl_view;
            srt_pkg::ADDR_RELOAD_LOW_BYTE: sfr_rdata <= reload_low_byte_q;
            srt_pkg::ADDR_RELOAD_HIGH_BYTE: sfr_rdata <= reload_high_byte_q;
            srt_pkg::ADDR_COUNT_LOW_BYTE: sfr_rdata <= count_low_byte_q;
            srt_pkg::ADDR_COUNT_HIGH_BYTE: sfr_rdata <= count_high_byte_q;
            default: sfr_rdata <= srt_pkg::READ_UNMAPPED;
         endcase
      end
   end

   // ****************************************************************
   // Interrupt request
   // ****************************************************************
   // Level request; it stays up until software clears the flags
   assign irq_request = timer_irq_enable & (high_overflow_flag_q
      | (low_byte_irq_enable_q & low_overflow_flag_q));

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_hi_flag_set: assert property (@(posedge ref_clk)
      disable iff (reset) wrap_hi |=> high_overflow_flag_q)
      else $error("high overflow flag missed");

   a_lo_flag_set: assert property (@(posedge ref_clk)
      disable iff (reset) wrap_lo |=> low_overflow_flag_q)
      else $error("low overflow flag missed");

   a_flag_sticky: assert property (@(posedge ref_clk)
      disable iff (reset)
      (high_overflow_flag_q && !wr_ctrl) |=> high_overflow_flag_q)
      else $error("high flag cleared without a write");

   a_lo_sticky: assert property (@(posedge ref_clk)
      disable iff (reset)
      (low_overflow_flag_q && !wr_ctrl) |=> low_overflow_flag_q)
      else $error("low flag cleared without a write");

   a_full_reload: assert property (@(posedge ref_clk)
      disable iff (reset)
      (!split_mode_select_q && run_control_q && tick_lo
       && count_low_byte_q == srt_pkg::BYTE_MAX
       && count_high_byte_q == srt_pkg::BYTE_MAX
       && !wr_cnt_lo && !wr_cnt_hi)
      |=> (count_low_byte_q == $past(reload_low_byte_q)
           && count_high_byte_q == $past(reload_high_byte_q)
           && high_overflow_flag_q))
      else $error("16-bit overflow did not reload");

   a_split_lo_reload: assert property (@(posedge ref_clk)
      disable iff (reset)
      (split_mode_select_q && tick_lo && !wr_cnt_lo
       && count_low_byte_q == srt_pkg::BYTE_MAX)
      |=> count_low_byte_q == $past(reload_low_byte_q))
      else $error("split low byte did not reload");

   a_split_lo_free: assert property (@(posedge ref_clk)
      disable iff (reset)
      (split_mode_select_q && !run_control_q && low_byte_clock_select
       && !wr_cnt_lo && count_low_byte_q != srt_pkg::BYTE_MAX)
      |=> count_low_byte_q == $past(count_low_byte_q) + srt_pkg::BYTE_ONE)
      else $error("split low byte stalled");

   a_hi_stopped: assert property (@(posedge ref_clk)
      disable iff (reset)
      (!run_control_q && !wr_cnt_hi) |=> $stable(count_high_byte_q))
      else $error("high byte moved while stopped");

   a_carry_16: assert property (@(posedge ref_clk)
      disable iff (reset)
      (!split_mode_select_q && run_control_q && low_byte_clock_select
       && !wr_cnt_hi && count_high_byte_q != srt_pkg::BYTE_MAX
       && count_low_byte_q == srt_pkg::BYTE_MAX)
      |=> count_high_byte_q == $past(count_high_byte_q) + srt_pkg::BYTE_ONE)
      else $error("carry into high byte lost");

   a_unused_zero: assert property (@(posedge ref_clk)
      disable iff (reset)
      (sfr_rd && sfr_addr == srt_pkg::ADDR_TIMER_CONTROL)
      |=> (sfr_rdata[srt_pkg::CTRL_UNUSED_HI] == 1'b0
           && sfr_rdata[srt_pkg::CTRL_UNUSED_LO] == 1'b0))
      else $error("unused control bits read non-zero");

   a_irq_low_src: assert property (@(posedge ref_clk)
      disable iff (reset)
      (wrap_lo && timer_irq_enable && low_byte_irq_enable_q
       && !wr_ctrl) |=> irq_request)
      else $error("low wrap gave no request");

   a_irq_high_src: assert property (@(posedge ref_clk)
      disable iff (reset)
      (wrap_hi && timer_irq_enable) |=> irq_request)
      else $error("high wrap gave no request");

   a_cnt_write: assert property (@(posedge ref_clk)
      disable iff (reset)
      wr_cnt_lo |=> count_low_byte_q == $past(sfr_wdata))
      else $error("low count write lost");

endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;

   // ****************************************************************
   // Clock, reset and stimulus signals
   // ****************************************************************
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic low_byte_clock_select = 1'b1;
   logic high_byte_clock_select = 1'b0;
   logic timer_irq_enable = 1'b0;
   logic ext_osc = 1'b0;
   logic irq_request;
   int num_errors = 0;
   int tests_run = 0;

   always #5 ref_clk = ~ref_clk;

   // Free-running oscillator, 40 ns period, offset so that its edges
   // never coincide with the system clock edges
   initial
   begin
      #3;
      forever #20 ext_osc = ~ext_osc;
   end

   srt_timer srt_timer_i (
      .ref_clk(ref_clk),
      .reset(reset),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .low_byte_clock_select(low_byte_clock_select),
      .high_byte_clock_select(high_byte_clock_select),
      .timer_irq_enable(timer_irq_enable),
      .ext_osc(ext_osc),
      .irq_request(irq_request)
   );

   // ****************************************************************
   // Access tasks
   // ****************************************************************
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h",
                  $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask

   // Data is registered at the taking edge, so it is looked at just after
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
      #1;
      d = sfr_rdata;
   endtask

   // Counting runs over exactly wt + 4 edges: from the edge after the
   // control write up to and including the edge that takes the stop write
   task automatic run_case(input logic [7:0] ctl, input logic [15:0] cnt,
                           input logic [15:0] rl, input logic [2:0] sel,
                           input int wt, input logic [7:0] e_ctl,
                           input logic [15:0] e_cnt, input logic e_irq);
      logic [7:0] d;
      @(posedge ref_clk);
      {low_byte_clock_select, high_byte_clock_select,
       timer_irq_enable} <= sel;
      wr(srt_pkg::ADDR_RELOAD_LOW_BYTE, rl[7:0]);
      wr(srt_pkg::ADDR_RELOAD_HIGH_BYTE, rl[15:8]);
      wr(srt_pkg::ADDR_COUNT_LOW_BYTE, cnt[7:0]);
      wr(srt_pkg::ADDR_COUNT_HIGH_BYTE, cnt[15:8]);
      wr(srt_pkg::ADDR_TIMER_CONTROL, ctl);
      repeat (wt) @(posedge ref_clk);
      rd(srt_pkg::ADDR_TIMER_CONTROL, d);
      chk(d, e_ctl, "control while counting");
      chk({7'h00, irq_request}, {7'h00, e_irq},
          "request while counting");
      wr(srt_pkg::ADDR_TIMER_CONTROL, 8'h00);
      rd(srt_pkg::ADDR_COUNT_LOW_BYTE, d);
      chk(d, e_cnt[7:0], "count low byte");
      rd(srt_pkg::ADDR_COUNT_HIGH_BYTE, d);
      chk(d, e_cnt[15:8], "count high byte");
      rd(srt_pkg::ADDR_TIMER_CONTROL, d);
      chk(d, 8'h00, "control after software clear");
      chk({7'h00, irq_request}, 8'h00,
          "request after clear");
      $display("test control %h done", ctl);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      logic [7:0] d;
      logic [7:0] addrs [5];
      addrs = '{srt_pkg::ADDR_TIMER_CONTROL, srt_pkg::ADDR_RELOAD_LOW_BYTE,
                srt_pkg::ADDR_RELOAD_HIGH_BYTE, srt_pkg::ADDR_COUNT_LOW_BYTE,
                srt_pkg::ADDR_COUNT_HIGH_BYTE};
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         rd(addrs[i], d);
         chk(d, 8'h00, "reset value");
      end
      chk({7'h00, irq_request}, 8'h00, "request after reset");
      $display("test reset values done");
      for (int i = 1; i < 5; i++)
         wr(addrs[i], 8'hA0 | 8'(i));
      for (int i = 1; i < 5; i++)
      begin
         rd(addrs[i], d);
         chk(d, 8'hA0 | 8'(i), "byte readback");
      end
      wr(srt_pkg::ADDR_TIMER_CONTROL, 8'h12);
      rd(srt_pkg::ADDR_TIMER_CONTROL, d);
      chk(d, 8'h00, "unused control bits");
      wr(srt_pkg::ADDR_TIMER_CONTROL, 8'h33);
      rd(srt_pkg::ADDR_TIMER_CONTROL, d);
      chk(d, 8'h21, "control with unused bits");
      wr(srt_pkg::ADDR_TIMER_CONTROL, 8'h00);
      wr(8'hC9, 8'hFF);
      rd(8'hC9, d);
      chk(d, srt_pkg::READ_UNMAPPED, "unmapped read");
      $display("test register access done");
      // 16-bit wrap, flag held for many cycles afterwards
      run_case(8'h04, 16'hFFF8, 16'h1234, 3'b101, 40, 8'hC4,
               16'h1258, 1'b1);
      run_case(8'h04, 16'hFFF8, 16'h1234, 3'b100, 10, 8'hC4,
               16'h123A, 1'b0);
      run_case(8'h24, 16'h00FA, 16'h1234, 3'b101, 10, 8'h64,
               16'h0108, 1'b1);
      run_case(8'h04, 16'h00FA, 16'h1234, 3'b101, 10, 8'h44,
               16'h0108, 1'b0);
      run_case(8'h20, 16'h00FA, 16'h1234, 3'b101, 10, 8'h20,
               16'h00FA, 1'b0);
      // Split mode: low byte counts with run off, high byte held; then both bytes count with run on
      run_case(8'h28, 16'h77FA, 16'h4080, 3'b111, 10, 8'h68,
               16'h7788, 1'b1);
      run_case(8'h2C, 16'hFE00, 16'h4080, 3'b111, 10, 8'hAC,
               16'h4C0E, 1'b1);
      // Windows of 120 and 320 edges hold a whole number of ticks
      run_case(8'h0C, 16'h0000, 16'h4080, 3'b101, 116, 8'h0C,
               16'h0A78, 1'b0);
      run_case(8'h04, 16'h0000, 16'h4080, 3'b011, 116, 8'h04,
               16'h000A, 1'b0);
      run_case(8'h05, 16'h0000, 16'h4080, 3'b011, 316, 8'h05,
               16'h000A, 1'b0);
      run_case(8'h0D, 16'h0000, 16'h4080, 3'b001, 316, 8'h0D,
               16'h0A0A, 1'b0);
      tally_and_finish();
   end

   // ****************************************************************
   // Watchdog
   // ****************************************************************
   // The sequence needs well under 3000 cycles; allow ample margin
   initial
   begin
      #200000;
      num_errors++;
      $display("wrong value at %0t: sequence did not complete", $time);
      tally_and_finish();
   end

endmodule
